// ==== hdl/cbu_pkg.sv ====
// Package: shared constants and types of the conditional branch unit
`default_nettype none
package cbu_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int PC_W  = 16;
	localparam int OFS_W = 7;

	// ----------------------------------------
	// Reset values and constants
	// ----------------------------------------
	localparam logic [PC_W-1:0] PC_RESET    = 16'h0000;
	localparam logic [PC_W-1:0] PC_STEP     = 16'h0001;
	localparam logic            FLAG_SET    = 1'b1;
	localparam logic            FLAG_CLEAR  = 1'b0;

	// ----------------------------------------
	// Timing in core cycles
	// ----------------------------------------
	localparam int CYC_NOT_TAKEN = 1;
	localparam int CYC_TAKEN     = 2;

	// ----------------------------------------
	// Branch operations
	// ----------------------------------------
	typedef enum logic [3:0] {
		CBU_OP_NONE,
		CBU_OP_BRANCH_IF_EQUAL,
		CBU_OP_BRANCH_IF_NOT_EQUAL,
		CBU_OP_BRANCH_IF_CARRY_SET,
		CBU_OP_BRANCH_IF_CARRY_CLEAR,
		CBU_OP_BRANCH_IF_SAME_OR_HIGHER,
		CBU_OP_BRANCH_IF_LOWER,
		CBU_OP_BRANCH_IF_MINUS,
		CBU_OP_BRANCH_IF_PLUS
	} cbu_op_t;

	typedef enum {
		CBU_ST_IDLE,
		CBU_ST_SECOND
	} cbu_state_t;

endpackage : cbu_pkg
`default_nettype wire

// ==== hdl/cbu_cond_if.sv ====
// Interface: condition request and verdict between the branch unit and its evaluator
`timescale 1ns/1ps
`default_nettype none
interface cbu_cond_if;
	import cbu_pkg::*;
	cbu_op_t op;
	logic    flag_zero;
	logic    flag_carry;
	logic    flag_negative;
	logic    taken;

	modport eval (input op, input flag_zero, input flag_carry, input flag_negative, output taken);
	modport user (output op, output flag_zero, output flag_carry, output flag_negative, input taken);
endinterface : cbu_cond_if
`default_nettype wire

// ==== hdl/cbu_cond_eval.sv ====
// Module: flag test of each conditional branch operation
`timescale 1ns/1ps
`default_nettype none
module cbu_cond_eval (
	cbu_cond_if.eval cif
);
	import cbu_pkg::*;

	// ----------------------------------------
	// Flag tests
	// ----------------------------------------
	wire zero_set   = (cif.flag_zero == FLAG_SET);
	wire carry_set  = (cif.flag_carry == FLAG_SET);
	wire minus_set  = (cif.flag_negative == FLAG_SET);

	wire hit_eq = (cif.op == CBU_OP_BRANCH_IF_EQUAL) && zero_set;           // [RULE_01]
	wire hit_ne = (cif.op == CBU_OP_BRANCH_IF_NOT_EQUAL) && !zero_set;      // [RULE_02]
	wire hit_cs = (cif.op == CBU_OP_BRANCH_IF_CARRY_SET) && carry_set;      // [RULE_03]
	wire hit_cc = (cif.op == CBU_OP_BRANCH_IF_CARRY_CLEAR) && !carry_set;   // [RULE_04]
	wire hit_sh = (cif.op == CBU_OP_BRANCH_IF_SAME_OR_HIGHER) && !carry_set; // [RULE_05]
	wire hit_lo = (cif.op == CBU_OP_BRANCH_IF_LOWER) && carry_set;          // [RULE_06]
	wire hit_mi = (cif.op == CBU_OP_BRANCH_IF_MINUS) && minus_set;          // [RULE_07]
	wire hit_pl = (cif.op == CBU_OP_BRANCH_IF_PLUS) && !minus_set;          // [RULE_08]

	// No-op never branches
	assign cif.taken = hit_eq | hit_ne | hit_cs | hit_cc | hit_sh | hit_lo | hit_mi | hit_pl;

endmodule : cbu_cond_eval
`default_nettype wire

// ==== hdl/cbu_branch_unit.sv ====
// Module: resolution of flag-conditional relative branches for the core
`timescale 1ns/1ps
`default_nettype none
// Operation
// RULE_01: Branch-if-equal loads PC with PC plus offset plus 1 when zero is 1, taking 1 cycle untaken and 2 taken.
// RULE_02: Branch-if-not-equal loads PC with PC plus offset plus 1 when zero is 0, else falls through.
// RULE_03: Branch-if-carry-set adds offset plus 1 to PC when carry is 1, else falls through.
// RULE_04: Branch-if-carry-clear adds offset plus 1 to PC when carry is 0, else falls through.
// RULE_05: Branch-if-same-or-higher is taken when carry is 0, loading PC plus offset plus 1.
// RULE_06: Branch-if-lower is taken when carry is 1, loading PC plus offset plus 1.
// RULE_07: Branch-if-minus adds offset plus 1 to PC when negative is 1, else falls through.
// RULE_08: Branch-if-plus adds offset plus 1 to PC when negative is 0, else falls through.
// RULE_09: No branch ever writes any status flag, taken or not.
// RULE_10: The offset is a signed two's-complement word count, so branches go forward or backward.
module cbu_branch_unit (
	input  wire logic                     clk_sys,
	input  wire logic                     rst_b,
	input  wire logic                     issue_valid,
	output logic                          issue_ready,
	input  wire cbu_pkg::cbu_op_t         issue_op,
	input  wire logic [cbu_pkg::OFS_W-1:0] issue_offset,
	input  wire logic [cbu_pkg::PC_W-1:0]  pc_current,
	input  wire logic                     flag_zero,
	input  wire logic                     flag_carry,
	input  wire logic                     flag_negative,
	output logic                          pc_load,
	output logic [cbu_pkg::PC_W-1:0]       pc_target,
	output logic                          fall_through,
	output logic                          branch_done,
	output logic                          flag_write_en
);
	import cbu_pkg::*;

	// ----------------------------------------
	// Condition evaluation
	// ----------------------------------------
	cbu_cond_if cif ();

	assign cif.op            = issue_op;
	assign cif.flag_zero     = flag_zero;
	assign cif.flag_carry    = flag_carry;
	assign cif.flag_negative = flag_negative;

	cbu_cond_eval u_eval (
		.cif (cif)
	);

	// ----------------------------------------
	// Target arithmetic
	// ----------------------------------------
	// Sign extension lets a negative offset step back; wraps at the PC width
	wire [PC_W-1:0] offset_ext = {{(PC_W-OFS_W){issue_offset[OFS_W-1]}}, issue_offset}; // [RULE_10]
	wire [PC_W-1:0] target_sum = pc_current + offset_ext + PC_STEP;                      // [RULE_10]

	// ----------------------------------------
	// Sequencing
	// ----------------------------------------
	cbu_state_t      state_reg;
	cbu_state_t      state_next;
	logic            pc_load_reg;
	logic [PC_W-1:0] pc_target_reg;
	logic            fall_through_reg;
	logic            done_reg;

	wire accept       = issue_valid && issue_ready;
	wire is_branch    = (issue_op != CBU_OP_NONE);
	wire go_taken     = accept && is_branch && cif.taken;
	wire go_untaken   = accept && !(is_branch && cif.taken);
	wire second_cycle = (state_reg == CBU_ST_SECOND);

	assign issue_ready = (state_reg == CBU_ST_IDLE);

	// Second cycle of a taken branch stalls the decoder while the fetch redirects
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			CBU_ST_IDLE: begin
				if (go_taken) begin
					state_next = CBU_ST_SECOND; // [RULE_01]
				end
			end
			CBU_ST_SECOND: begin
				state_next = CBU_ST_IDLE;
			end
			default: begin
				state_next = CBU_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= CBU_ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pc_load_reg      <= 1'b0;
			pc_target_reg    <= PC_RESET;
			fall_through_reg <= 1'b0;
			done_reg         <= 1'b0;
		end else begin
			pc_load_reg      <= go_taken; // [RULE_02]
			fall_through_reg <= go_untaken;
			done_reg         <= go_untaken || second_cycle; // [RULE_01]
			if (go_taken) begin
				pc_target_reg <= target_sum; // [RULE_03]
			end
		end
	end

	assign pc_load       = pc_load_reg;
	assign pc_target     = pc_target_reg;
	assign fall_through  = fall_through_reg;
	assign branch_done   = done_reg;
	// Branches only read flags; the status register is never written from here
	assign flag_write_en = 1'b0; // [RULE_09]

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_eq_taken: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE_01]
		accept && issue_op == CBU_OP_BRANCH_IF_EQUAL && flag_zero |->
		##1 (pc_load && !issue_ready && pc_target == $past(pc_current) + PC_STEP
			+ {{(PC_W-OFS_W){$past(issue_offset[OFS_W-1])}}, $past(issue_offset)})
		##1 (branch_done && issue_ready))
		else $error("equal branch not taken in two cycles");

	a_ne_branch: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE_02]
		accept && issue_op == CBU_OP_BRANCH_IF_NOT_EQUAL |=>
		(pc_load == !$past(flag_zero)) && (fall_through == $past(flag_zero)))
		else $error("not-equal branch decision wrong");

	a_cs_branch: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE_03]
		accept && issue_op == CBU_OP_BRANCH_IF_CARRY_SET |=> pc_load == $past(flag_carry))
		else $error("carry-set branch decision wrong");

	a_cc_branch: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE_04]
		accept && issue_op == CBU_OP_BRANCH_IF_CARRY_CLEAR |=> pc_load == !$past(flag_carry))
		else $error("carry-clear branch decision wrong");

	a_sh_branch: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE_05]
		accept && issue_op == CBU_OP_BRANCH_IF_SAME_OR_HIGHER && !flag_carry |=>
		pc_load && !fall_through && pc_target == $past(pc_current) + PC_STEP
			+ {{(PC_W-OFS_W){$past(issue_offset[OFS_W-1])}}, $past(issue_offset)})
		else $error("same-or-higher branch not taken");

	a_lo_branch: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE_06]
		accept && issue_op == CBU_OP_BRANCH_IF_LOWER |=>
		(pc_load == $past(flag_carry)) && (fall_through == !$past(flag_carry)))
		else $error("lower branch decision wrong");

	a_mi_branch: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE_07]
		accept && issue_op == CBU_OP_BRANCH_IF_MINUS |=> pc_load == $past(flag_negative))
		else $error("minus branch decision wrong");

	a_pl_branch: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE_08]
		accept && issue_op == CBU_OP_BRANCH_IF_PLUS |=> pc_load == !$past(flag_negative))
		else $error("plus branch decision wrong");

	a_flags_kept: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE_09]
		(pc_load || fall_through || branch_done) |-> !flag_write_en)
		else $error("branch wrote status flags");

	a_offset_signed: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE_10]
		go_taken && issue_offset[OFS_W-1] |=>
		($past(pc_current) - pc_target) == ~{{(PC_W-OFS_W){1'b1}}, $past(issue_offset)})
		else $error("backward offset not sign extended");

	a_untaken_one: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE_01]
		go_untaken |=> branch_done && fall_through && !pc_load && issue_ready)
		else $error("untaken branch not done in one cycle");

	// ----------------------------------------
	// Timing and target checks
	// ----------------------------------------
	a_eq_untaken: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE_01]
		accept && issue_op == CBU_OP_BRANCH_IF_EQUAL && !flag_zero |=>
		fall_through && !pc_load && issue_ready)
		else $error("equal branch taken with zero clear");

	a_taken_stall: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE_01]
		go_taken |=> !issue_ready ##1 issue_ready)
		else $error("taken branch stall not exactly one cycle");

	a_load_retire: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE_01]
		pc_load |=> branch_done && !pc_load && !fall_through)
		else $error("taken branch not retired after load");

	a_stall_refuse: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE_01]
		!issue_ready |=> !pc_load && !fall_through)
		else $error("request taken while stalled");

	a_one_result: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE_01]
		pc_load |-> !fall_through)
		else $error("load and fall-through together");

	a_target_hold: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE_03]
		!pc_load |-> pc_target == $past(pc_target))
		else $error("target moved without a load");

	a_sh_fall: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE_05]
		accept && issue_op == CBU_OP_BRANCH_IF_SAME_OR_HIGHER && flag_carry |=>
		fall_through && !pc_load)
		else $error("same-or-higher branch taken with carry set");

	a_pl_fall: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE_08]
		accept && issue_op == CBU_OP_BRANCH_IF_PLUS && flag_negative |=>
		fall_through && branch_done && !pc_load)
		else $error("plus branch taken with negative set");

	a_fwd_offset: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE_10]
		go_taken && !issue_offset[OFS_W-1] |=>
		(pc_target - $past(pc_current)) == {{(PC_W-OFS_W){1'b0}}, $past(issue_offset)} + PC_STEP)
		else $error("forward offset target wrong");

	a_ne_target: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE_02]
		accept && issue_op == CBU_OP_BRANCH_IF_NOT_EQUAL && !flag_zero |=>
		pc_target == $past(pc_current) + PC_STEP
			+ {{(PC_W-OFS_W){$past(issue_offset[OFS_W-1])}}, $past(issue_offset)})
		else $error("not-equal branch target wrong");

endmodule : cbu_branch_unit
`default_nettype wire

// ==== tb/conditional_branch_unit_tb_top.sv ====
// Testbench: self-checking bench for the conditional branch unit
`timescale 1ns/1ps
`default_nettype none
module conditional_branch_unit_tb_top;
	import cbu_pkg::*;
	// ----------------------------------------
	// Signals and design
	// ----------------------------------------
	logic              clk_sys = 1'b0;
	logic              rst_b;
	logic              issue_valid;
	logic              issue_ready;
	cbu_op_t           issue_op;
	logic [OFS_W-1:0]  issue_offset;
	logic [PC_W-1:0]   pc_current;
	logic              flag_zero;
	logic              flag_carry;
	logic              flag_negative;
	logic              pc_load;
	logic [PC_W-1:0]   pc_target;
	logic              fall_through;
	logic              branch_done;
	logic              flag_write_en;
	int                err_total = 0;
	int                tests_run = 0;
	int                r, o, f, t;
	logic [31:0]       lfsr_reg = 32'hB6ED;
	logic              m_ready, m_pend, e_load, e_ft, e_done;
	logic [PC_W-1:0]   e_tgt;

	always #25 clk_sys = ~clk_sys;

	cbu_branch_unit dut (.clk_sys(clk_sys), .rst_b(rst_b), .issue_valid(issue_valid), .issue_ready(issue_ready),
		.issue_op(issue_op), .issue_offset(issue_offset), .pc_current(pc_current), .flag_zero(flag_zero),
		.flag_carry(flag_carry), .flag_negative(flag_negative), .pc_load(pc_load), .pc_target(pc_target),
		.fall_through(fall_through), .branch_done(branch_done), .flag_write_en(flag_write_en));

	// ----------------------------------------
	// Reporting
	// ----------------------------------------
	task automatic close_out();
		if (err_total == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out

	task automatic chk_bit(input logic got, input logic exp, input string what);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
		end
	endtask : chk_bit

	task automatic chk_word(input logic [PC_W-1:0] got, input logic [PC_W-1:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk_word

	function automatic logic [31:0] lfsr_step(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_step

	// ----------------------------------------
	// Reference model
	// ----------------------------------------
	function automatic logic m_taken(input cbu_op_t op, input logic z, input logic c, input logic n);
		case (op)
			CBU_OP_BRANCH_IF_EQUAL:          return z == 1'b1;
			CBU_OP_BRANCH_IF_NOT_EQUAL:      return z == 1'b0;
			CBU_OP_BRANCH_IF_CARRY_SET:      return c == 1'b1;
			CBU_OP_BRANCH_IF_CARRY_CLEAR:    return c == 1'b0;
			CBU_OP_BRANCH_IF_SAME_OR_HIGHER: return c == 1'b0;
			CBU_OP_BRANCH_IF_LOWER:          return c == 1'b1;
			CBU_OP_BRANCH_IF_MINUS:          return n == 1'b1;
			CBU_OP_BRANCH_IF_PLUS:           return n == 1'b0;
			default:                         return 1'b0;
		endcase
	endfunction : m_taken

	// Inputs read before the edge's updates land, outputs 1 ns later
	always @(posedge clk_sys) begin
		{e_load, e_ft, e_done} = 3'b000;
		if (!rst_b) begin
			{m_ready, m_pend, e_tgt} = {1'b1, 1'b0, 16'h0000};
		end else if (m_pend) begin
			{m_ready, m_pend, e_done} = 3'b101;
		end else if (issue_valid && m_ready) begin
			if (m_taken(issue_op, flag_zero, flag_carry, flag_negative)) begin
				t = int'(pc_current) + int'($signed(issue_offset)) + 1;
				e_tgt = t[PC_W-1:0];
				{e_load, m_ready, m_pend} = 3'b101;
			end else begin
				{e_ft, e_done} = 2'b11;
			end
		end
		#1;
		if (!rst_b) begin
			{m_ready, m_pend, e_tgt, e_load, e_ft, e_done} = {1'b1, 1'b0, 16'h0000, 3'b000};
		end
		chk_bit(pc_load, e_load, "pc_load");
		chk_bit(fall_through, e_ft, "fall_through");
		chk_bit(branch_done, e_done, "branch_done");
		chk_bit(issue_ready, m_ready, "issue_ready");
		chk_word(pc_target, e_tgt, "pc_target");
		chk_bit(flag_write_en, 1'b0, "flag_write_en");
	end

	// ----------------------------------------
	// Stimulus
	// ----------------------------------------
	// Next request rides on the accept edge, so a stalled one is held
	task automatic issue(input cbu_op_t op, input logic [2:0] fl, input logic [PC_W-1:0] pc,
		input logic [OFS_W-1:0] k);
		int n;
		issue_valid <= 1'b1;
		issue_op <= op;
		{flag_zero, flag_carry, flag_negative} <= fl;
		pc_current <= pc;
		issue_offset <= k;
		for (n = 0; n < 4; n++) begin
			@(posedge clk_sys);
			if (issue_ready === 1'b1)
				break;
		end
		if (n == 4) begin
			err_total++;
			$display("[ERR] %0t accept timeout", $time);
			close_out();
		end
	endtask : issue

	task automatic pause(input int n);
		issue_valid <= 1'b0;
		repeat (n) @(posedge clk_sys);
	endtask : pause

	initial begin
		{rst_b, issue_valid, flag_zero, flag_carry, flag_negative} <= 5'b00000;
		issue_op <= CBU_OP_NONE;
		issue_offset <= 7'h00;
		pc_current <= 16'h0000;
		repeat (2) @(posedge clk_sys);
		rst_b <= 1'b1;
		issue(CBU_OP_BRANCH_IF_EQUAL, 3'b100, 16'hFFFF, 7'h01);
		issue(CBU_OP_BRANCH_IF_NOT_EQUAL, 3'b000, 16'h0010, 7'h7E);
		issue(CBU_OP_BRANCH_IF_CARRY_SET, 3'b010, 16'h0000, 7'h40);
		issue(CBU_OP_BRANCH_IF_MINUS, 3'b001, 16'h1234, 7'h3F);
		for (r = 0; r < 3; r++)
			for (o = 0; o < 9; o++)
				for (f = 0; f < 8; f++) begin
					lfsr_reg = lfsr_step(lfsr_reg);
					if (lfsr_reg[3:0] == 4'h0)
						pause(1);
					issue(cbu_op_t'(o), f[2:0], lfsr_reg[31:16], lfsr_reg[OFS_W-1:0]);
				end
		// Reset while a taken branch is still retiring
		issue(CBU_OP_BRANCH_IF_PLUS, 3'b000, 16'h0100, 7'h05);
		@(posedge clk_sys);
		rst_b <= 1'b0;
		pause(2);
		rst_b <= 1'b1;
		issue(CBU_OP_BRANCH_IF_LOWER, 3'b010, 16'h0200, 7'h10);
		pause(4);
		#2;
		close_out();
	end
endmodule : conditional_branch_unit_tb_top
`default_nettype wire
